/* hdl/sss_servo.sv */
// spindle speed servo: reference divider, discriminator, run control, commutation
// Contract
// - oscillator halved to form reference clock
// - reference timing only from oscillator input
// - speed_select high 1388, low 1666
// - error pulse width follows period difference
// - rpm equals 60 fref over 2n z
// - tachometer squared with hysteresis first
// - run_stop_control low runs, high standby
// - hall bias on only while running
// - thermal shutdown at 170, resume 140
// - phase outputs lead hall by 30
`timescale 1ns/1ps
`default_nettype none
module sss_servo
	import sss_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic osc_in, // oscillator level
	output logic osc_out, // oscillator feedback drive
	input wire logic speed_select, // high: short target
	input wire logic run_stop_control, // high: standby
	input wire logic tach_feedback, // tachometer comparator level
	input wire logic temp_hot, // junction at shutdown level
	input wire logic temp_cool, // junction at release level
	input wire logic [2:0] hall_in, // hall comparator levels
	output logic [2:0] phase_src, // phase sources current
	output logic [2:0] phase_snk, // phase sinks current
	output logic hall_bias_on, // hall bias switch closed
	output logic ref_tick, // reference clock pulse
	output logic speed_err_accel, // error: speed up
	output logic speed_err_decel, // error: slow down
	output logic standby, // in standby
	output logic thermal_shutdown // thermal latch set
);
	// ----------------------------------------
	// run and thermal control
	// ----------------------------------------
	logic therm_q, therm_d;
	logic active;

	always_comb
	begin
		therm_d = therm_q;
		if (temp_hot)
			therm_d = 1'b1;
		else if (temp_cool)
			therm_d = 1'b0;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			therm_q <= 1'b0;
		else
			therm_q <= therm_d;
	end

	assign active = !run_stop_control && !therm_q;
	assign standby = run_stop_control;
	assign thermal_shutdown = therm_q;
	assign hall_bias_on = active;
	// inverter drive, unused with external clock
	assign osc_out = ~osc_in;

	// ----------------------------------------
	// reference divider
	// ----------------------------------------
	logic osc_prev_q, osc_prev_d;
	logic [1:0] div_q, div_d;
	logic tick_q, tick_d;

	always_comb
	begin
		osc_prev_d = osc_in;
		div_d = div_q;
		tick_d = 1'b0;
		if (!active)
			div_d = 2'h0;
		else if (osc_in && !osc_prev_q)
		begin
			if (div_q == DIV_PHASE_LAST)
			begin
				div_d = 2'h0;
				tick_d = 1'b1;
			end
			else
				div_d = div_q + 2'h1;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			osc_prev_q <= 1'b0;
			div_q <= 2'h0;
			tick_q <= 1'b0;
		end
		else
		begin
			osc_prev_q <= osc_prev_d;
			div_q <= div_d;
			tick_q <= tick_d;
		end
	end

	assign ref_tick = tick_q;

	// ----------------------------------------
	// tachometer squaring
	// ----------------------------------------
	logic tach_sq;

	sss_hyst #(.SAMPLES(HYST_SAMPLES)) u_tach_sq
	(
		.mclk(mclk),
		.nrst(nrst),
		.clr(!active),
		.raw(tach_feedback),
		.sq(tach_sq)
	);

	// ----------------------------------------
	// speed discriminator
	// ----------------------------------------
	logic tach_prev_q, tach_prev_d;
	logic [CNT_W-1:0] per_q, per_d;
	logic [CNT_W-1:0] pw_q, pw_d;
	logic [CNT_W-1:0] target;
	logic primed_q, primed_d;
	sss_err_t err_q, err_d;

	assign target = speed_select ? CNT_HIGH_SPEED : CNT_LOW_SPEED;

	always_comb
	begin
		tach_prev_d = tach_sq;
		per_d = per_q;
		pw_d = pw_q;
		primed_d = primed_q;
		err_d = err_q;
		if (tick_q && per_q != CNT_MAX)
			per_d = per_q + CNT_ONE;
		if (tick_q && pw_q != CNT_ZERO)
		begin
			pw_d = pw_q - CNT_ONE;
			if (pw_q == CNT_ONE)
				err_d = SSS_IDLE;
		end
		if (!active)
		begin
			per_d = CNT_ZERO;
			pw_d = CNT_ZERO;
			primed_d = 1'b0;
			err_d = SSS_IDLE;
		end
		else if (tach_sq && !tach_prev_q)
		begin
			// tick in the edge cycle opens the new period, so none is lost
			per_d = tick_q ? CNT_ONE : CNT_ZERO;
			primed_d = 1'b1;
			if (primed_q)
			begin
				if (per_q > target)
				begin
					err_d = SSS_ACCEL;
					pw_d = per_q - target;
				end
				else if (per_q < target)
				begin
					err_d = SSS_DECEL;
					pw_d = target - per_q;
				end
				else
				begin
					err_d = SSS_IDLE;
					pw_d = CNT_ZERO;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			tach_prev_q <= 1'b0;
			per_q <= CNT_ZERO;
			pw_q <= CNT_ZERO;
			primed_q <= 1'b0;
			err_q <= SSS_IDLE;
		end
		else
		begin
			tach_prev_q <= tach_prev_d;
			per_q <= per_d;
			pw_q <= pw_d;
			primed_q <= primed_d;
			err_q <= err_d;
		end
	end

	// lock where period equals target count
	assign speed_err_accel = (err_q == SSS_ACCEL);
	assign speed_err_decel = (err_q == SSS_DECEL);

	// ----------------------------------------
	// commutation
	// ----------------------------------------
	logic [2:0] src_q, src_d, snk_q, snk_d;

	always_comb
	begin
		src_d = 3'h0;
		snk_d = 3'h0;
		// hall difference leads by 30 degrees
		if (active)
		begin
			for (int i = 0; i < 3; i++)
			begin
				src_d[i] = hall_in[i] && !hall_in[(i + 1) % 3];
				snk_d[i] = !hall_in[i] && hall_in[(i + 1) % 3];
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			src_q <= 3'h0;
			snk_q <= 3'h0;
		end
		else
		begin
			src_q <= src_d;
			snk_q <= snk_d;
		end
	end

	assign phase_src = src_q;
	assign phase_snk = snk_q;
endmodule
`default_nettype wire

/* hdl/sss_pkg.sv */
// constants and types shared by the spindle speed servo
package sss_pkg;
	// ----------------------------------------
	// discriminator targets
	// ----------------------------------------
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] CNT_HIGH_SPEED = 12'h56c; // 1388
	localparam logic [CNT_W-1:0] CNT_LOW_SPEED = 12'h682;  // 1666
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;

	// ----------------------------------------
	// clock and speed relation
	// ----------------------------------------
	localparam int OSC_DIV = 2;
	localparam int SEC_PER_MIN = 60;
	localparam int TACH_TEETH_DEFAULT = 60;
	localparam int HYST_SAMPLES = 4;
	localparam logic [1:0] DIV_PHASE_LAST = 2'(OSC_DIV - 1);

	// locked speed in rpm from oscillator rate, target count and tooth count
	function automatic int locked_rpm(input int f_osc_hz, input int count, input int teeth);
		locked_rpm = (SEC_PER_MIN * (f_osc_hz / OSC_DIV)) / (2 * count) / teeth;
	endfunction

	// ----------------------------------------
	// discriminator states
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		SSS_IDLE = 2'b00,
		SSS_ACCEL = 2'b01,
		SSS_DECEL = 2'b10
	} sss_err_t;
endpackage

/* hdl/sss_hyst.sv */
// input squaring stage with sample hysteresis
`timescale 1ns/1ps
`default_nettype none
module sss_hyst
	import sss_pkg::*;
#(
	parameter int SAMPLES = HYST_SAMPLES
)
(
	input wire logic mclk, // system clock
	input wire logic nrst, // async reset, active low
	input wire logic clr, // hold at low level
	input wire logic raw, // raw comparator level
	output logic sq // squared level
);
	localparam int CW = $clog2(SAMPLES + 1);
	localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);
	localparam logic [CW-1:0] ZERO = '0;

	logic [CW-1:0] cnt_q, cnt_d;
	logic sq_q, sq_d;

	// ----------------------------------------
	// level changes only after a stable run
	// ----------------------------------------
	always_comb
	begin
		cnt_d = ZERO;
		sq_d = sq_q;
		if (clr)
		begin
			sq_d = 1'b0;
		end
		else if (raw != sq_q)
		begin
			if (cnt_q == LAST)
				sq_d = raw;
			else
				cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_q <= '0;
			sq_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			sq_q <= sq_d;
		end
	end

	assign sq = sq_q;
endmodule
`default_nettype wire

/* tb/sss_servo_monitor.sv */
// port checker for the speed servo
`timescale 1ns/1ps
`default_nettype none
module sss_servo_monitor
(
	input wire logic mclk, // clock
	input wire logic nrst, // reset
	input wire logic osc_in, // osc
	input wire logic osc_out, // osc drive
	input wire logic run_stop_control, // stop
	input wire logic temp_hot, // hot
	input wire logic temp_cool, // cool
	input wire logic [2:0] hall_in, // hall
	input wire logic [2:0] phase_src, // src
	input wire logic [2:0] phase_snk, // snk
	input wire logic hall_bias_on, // bias
	input wire logic ref_tick, // tick
	input wire logic standby, // standby
	input wire logic thermal_shutdown // latch
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	property p_osc;
		osc_out == !osc_in;
	endproperty
	a_osc: assert property (p_osc) else $error("osc_out not inverted");
	property p_tick;
		ref_tick |=> !ref_tick [*3];
	endproperty
	a_tick: assert property (p_tick) else $error("tick too close");
	property p_bias;
		hall_bias_on == (!run_stop_control && !thermal_shutdown);
	endproperty
	a_bias: assert property (p_bias) else $error("bias wrong");
	property p_stby;
		standby == run_stop_control;
	endproperty
	a_stby: assert property (p_stby) else $error("standby wrong");
	property p_hot;
		temp_hot |=> thermal_shutdown;
	endproperty
	a_hot: assert property (p_hot) else $error("latch not set");
	property p_cool;
		thermal_shutdown && temp_cool && !temp_hot |=> !thermal_shutdown;
	endproperty
	a_cool: assert property (p_cool) else $error("latch not cleared");
	property p_src;
		hall_bias_on && !temp_hot |=> phase_src == ($past(hall_in) & ~{$past(hall_in[0]), $past(hall_in[2:1])});
	endproperty
	a_src: assert property (p_src) else $error("source phase wrong");
	property p_snk;
		hall_bias_on && !temp_hot |=> phase_snk == (~$past(hall_in) & {$past(hall_in[0]), $past(hall_in[2:1])});
	endproperty
	a_snk: assert property (p_snk) else $error("sink phase wrong");
	property p_stop_phase;
		!hall_bias_on |=> phase_src == 3'h0 && phase_snk == 3'h0;
	endproperty
	a_stop_phase: assert property (p_stop_phase) else $error("phases driven while stopped");
endmodule
`default_nettype wire

/* tb/sss_motor_model.sv */
// tachometer, hall and oscillator source
`timescale 1ns/1ps
`default_nettype none
module sss_motor_model
(
	input wire logic mclk, // clock
	input wire logic nrst, // restart
	input wire logic [15:0] half, // tach half period
	output logic osc_in, // oscillator
	output logic tach_feedback, // tach level
	output logic [2:0] hall_in // hall levels
);
	localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	logic [15:0] cnt = 16'h0000;
	logic [2:0] hs = 3'h0;
	initial osc_in = 1'b0;
	initial tach_feedback = 1'b0;
	assign hall_in = SEQ[hs];
	always @(posedge mclk)
	begin
		osc_in <= #1 !osc_in;
		hs <= #1 (hs == 3'h5) ? 3'h0 : hs + 3'h1;
		if (!nrst || cnt == half - 16'h0001)
		begin
			cnt <= #1 16'h0000;
			tach_feedback <= #1 nrst && !tach_feedback;
		end
		else
			cnt <= #1 cnt + 16'h0001;
	end
endmodule
`default_nettype wire

/* tb/sss_servo_tb.sv */
// speed servo testbench
`timescale 1ns/1ps
`default_nettype none
module sss_servo_tb;
	import sss_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic speed_select = 1'b1;
	logic run_stop_control = 1'b0;
	logic temp_hot = 1'b0;
	logic temp_cool = 1'b0;
	logic [15:0] half = 16'h0800;
	logic osc_in, osc_out, tach_feedback, hall_bias_on, ref_tick;
	logic speed_err_accel, speed_err_decel, standby, thermal_shutdown;
	logic [2:0] hall_in, phase_src, phase_snk;
	int error_cnt = 0;
	int checks = 0;
	sss_motor_model motor (.mclk, .nrst, .half, .osc_in, .tach_feedback, .hall_in);
	sss_servo dut (.mclk, .nrst, .osc_in, .osc_out, .speed_select, .run_stop_control, .tach_feedback,
		.temp_hot, .temp_cool, .hall_in, .phase_src, .phase_snk, .hall_bias_on, .ref_tick,
		.speed_err_accel, .speed_err_decel, .standby, .thermal_shutdown);
	initial
	begin
		forever #2.5 mclk = !mclk;
	end
	task step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_disc(input logic sel, input int per, input int ea, input int ed);
		int na;
		int nd;
		na = 0;
		nd = 0;
		speed_select = sel;
		half = 16'(2 * per);
		nrst = 1'b0;
		step(20);
		nrst = 1'b1;
		repeat (8 * per + 100)
		begin
			step(1);
			// pulse width counted in reference ticks, free of tick phase
			na += int'(speed_err_accel === 1'b1 && ref_tick === 1'b1);
			nd += int'(speed_err_decel === 1'b1 && ref_tick === 1'b1);
		end
		chk("accel ticks", 16'(na), 16'(ea));
		chk("decel ticks", 16'(nd), 16'(ed));
	endtask
	task t_stby;
		run_stop_control = 1'b1;
		step(2);
		chk("standby", 16'(standby), 16'h0001);
		chk("bias", 16'(hall_bias_on), 16'h0000);
		chk("phases", 16'({phase_src, phase_snk}), 16'h0000);
		run_stop_control = 1'b0;
		step(2);
		chk("bias", 16'(hall_bias_on), 16'h0001);
	endtask
	task t_therm;
		temp_hot = 1'b1;
		step(1);
		temp_hot = 1'b0;
		step(20);
		chk("latch", 16'(thermal_shutdown), 16'h0001);
		chk("bias", 16'(hall_bias_on), 16'h0000);
		temp_cool = 1'b1;
		step(1);
		temp_cool = 1'b0;
		step(1);
		chk("latch", 16'(thermal_shutdown), 16'h0000);
	endtask
	initial
	begin
		step(20);
		nrst = 1'b1;
		t_stby;
		t_therm;
		t_disc(1'b1, 1400, 1400 - int'(CNT_HIGH_SPEED), 0);
		t_disc(1'b0, 1660, 0, int'(CNT_LOW_SPEED) - 1660);
		t_disc(1'b1, 1388, 0, 0);
		end_sim;
	end
	// run needs about 36k cycles
	initial
	begin
		#300000;
		error_cnt++;
		end_sim;
	end
endmodule
bind sss_servo sss_servo_monitor mon (.mclk, .nrst, .osc_in, .osc_out, .run_stop_control, .temp_hot,
	.temp_cool, .hall_in, .phase_src, .phase_snk, .hall_bias_on, .ref_tick, .standby, .thermal_shutdown);
`default_nettype wire
